/* src/pos_loop_top.sv */
// Position command gear, smoothing filter and proportional position loop
//
// Behaviour
// - First numerator register holds 1..32767, reset value 1.
// - Second numerator register holds 1..32767, reset value 1.
// - One shared denominator register holds 1..32767, reset value 1.
// - A digital input given function code 11 selects the numerator.
// - Without that assignment only the first numerator is used.
// - Command pulse count is scaled by numerator over denominator.
// - Command low-pass time constant 0..1000 in 10 ms units, zero bypasses.
// - Proportional position gain 0..1023 rad/s, reset value 50.
// - Automatic tuning overwrites position gain and feed-forward gain.
// - Gain switch condition scales position gain by 10..500 percent.
// - Feed-forward gain 0..100 percent added to the command, default 0.
// - Feed-forward path smoothed with 2..100 ms, default 5.
`default_nettype none
`include "pos_loop_consts.svh"
module pos_loop_top #(
  parameter int TICK_CYCLES = `TICK_NS / `CLK_PERIOD_NS
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic ARST_N,
  // Avalon-MM slave
  input wire logic [11:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // Command pulses from the motion controller
  input wire logic CMD_STEP,
  input wire logic CMD_DIR,
  // Digital input and gain switch condition
  input wire logic NUM_SEL_IN,
  input wire logic GAIN_SW_COND,
  // Encoder feedback pulses
  input wire logic FB_STEP,
  input wire logic FB_DIR,
  // Motor side outputs
  output wire logic MOTOR_STEP,
  output wire logic MOTOR_DIR,
  output logic [31:0] SPEED_CMD
);
  // ==========================================================
  // Helpers
  function automatic pos_loop_pkg::word_t wmerge(input pos_loop_pkg::word_t old,
      input logic [15:0] d, input logic [1:0] be);
    wmerge = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
  endfunction

  function automatic logic in_rng(input pos_loop_pkg::word_t v,
      input pos_loop_pkg::word_t lo, input pos_loop_pkg::word_t hi);
    in_rng = (v >= lo) && (v <= hi);
  endfunction

  // Floor of log2, turns a time constant into a filter shift
  function automatic logic [4:0] log2fl(input logic [15:0] v);
    log2fl = 5'h00;
    for (int i = 0; i < 16; i++) begin
      if (v[i]) begin
        log2fl = 5'(i);
      end
    end
  endfunction

  // ==========================================================
  // Reset release
  logic [1:0] rst_sync_reg;
  logic rst_n;

  // Assert at once, release through two flops
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // ==========================================================
  // Bus slave
  logic bus_req;
  logic [9:0] idx;
  logic aligned;
  logic wr_en;
  logic [15:0] wd;
  logic [1:0] be;
  assign bus_req = AVS_READ | AVS_WRITE;
  assign idx = AVS_ADDRESS[11:2];
  assign aligned = AVS_ADDRESS[1:0] == 2'b00;
  assign wr_en = AVS_WRITE & ~AVS_WAITREQUEST & aligned;
  assign wd = AVS_WRITEDATA[15:0];
  assign be = AVS_BYTEENABLE[1:0];

  // Every access waits exactly one cycle, then completes
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      AVS_WAITREQUEST <= 1'b1;
    end else begin
      AVS_WAITREQUEST <= ~(bus_req & AVS_WAITREQUEST);
    end
  end

  // ==========================================================
  // Parameter registers, out of range writes are dropped
  pos_loop_pkg::word_t num1_reg, num2_reg, den_reg, pgain_reg, rate_reg;
  pos_loop_pkg::word_t ffg_reg, ffsm_reg, ctrl_reg, lpf_reg;
  logic auto_mode;
  logic [3:0] level;
  assign auto_mode = ctrl_reg[`CTRL_AUTO_BIT];
  assign level = ctrl_reg[`CTRL_LVL_MSB:`CTRL_LVL_LSB];

  // First numerator
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      num1_reg <= `RST_GEAR;
    end else if (wr_en && idx == `IDX_NUM1 && in_rng(wmerge(num1_reg, wd, be),
        `GEAR_MIN, `GEAR_MAX)) begin
      num1_reg <= wmerge(num1_reg, wd, be);
    end
  end

  // Second numerator
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      num2_reg <= `RST_GEAR;
    end else if (wr_en && idx == `IDX_NUM2 && in_rng(wmerge(num2_reg, wd, be),
        `GEAR_MIN, `GEAR_MAX)) begin
      num2_reg <= wmerge(num2_reg, wd, be);
    end
  end

  // Shared denominator
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      den_reg <= `RST_GEAR;
    end else if (wr_en && idx == `IDX_DEN && in_rng(wmerge(den_reg, wd, be),
        `GEAR_MIN, `GEAR_MAX)) begin
      den_reg <= wmerge(den_reg, wd, be);
    end
  end

  // Position gain, the tuning table wins over software in auto mode
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      pgain_reg <= `RST_PGAIN;
    end else if (auto_mode) begin
      pgain_reg <= 16'(`AUTO_PGAIN_BASE + level * `AUTO_PGAIN_STEP);
    end else if (wr_en && idx == `IDX_PGAIN && in_rng(wmerge(pgain_reg, wd, be),
        `PGAIN_MIN, `PGAIN_MAX)) begin
      pgain_reg <= wmerge(pgain_reg, wd, be);
    end
  end

  // Gain switching rate
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      rate_reg <= `RST_RATE;
    end else if (wr_en && idx == `IDX_RATE && in_rng(wmerge(rate_reg, wd, be),
        `RATE_MIN, `RATE_MAX)) begin
      rate_reg <= wmerge(rate_reg, wd, be);
    end
  end

  // Feed-forward gain, overwritten like the position gain
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      ffg_reg <= `RST_FFG;
    end else if (auto_mode) begin
      ffg_reg <= 16'(`AUTO_FFG_BASE + level * `AUTO_FFG_STEP);
    end else if (wr_en && idx == `IDX_FFG && in_rng(wmerge(ffg_reg, wd, be),
        `FFG_MIN, `FFG_MAX)) begin
      ffg_reg <= wmerge(ffg_reg, wd, be);
    end
  end

  // Feed-forward smoothing time
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      ffsm_reg <= `RST_FFSM;
    end else if (wr_en && idx == `IDX_FFSM && in_rng(wmerge(ffsm_reg, wd, be),
        `FFSM_MIN, `FFSM_MAX)) begin
      ffsm_reg <= wmerge(ffsm_reg, wd, be);
    end
  end

  // Control word and low-pass time constant
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= `RST_CTRL;
      lpf_reg <= `RST_LPF;
    end else if (wr_en && idx == `IDX_CTRL) begin
      ctrl_reg <= wmerge(ctrl_reg, wd, be);
    end else if (wr_en && idx == `IDX_LPF && in_rng(wmerge(lpf_reg, wd, be),
        `LPF_MIN, `LPF_MAX)) begin
      lpf_reg <= wmerge(lpf_reg, wd, be);
    end
  end

  // ==========================================================
  // Numerator selection and gear
  logic sel_assigned;
  logic sel_second_reg;
  pos_loop_pkg::word_t active_num_reg;
  pos_loop_pkg::step_s cmd_s;
  pos_loop_pkg::step_s gear_out;
  logic gear_busy;
  assign sel_assigned = ctrl_reg[`CTRL_FUNC_MSB:`CTRL_FUNC_LSB] == `FUNC_NUMSEL;
  assign cmd_s = '{step: CMD_STEP, dir: CMD_DIR};

  // Unassigned input falls back to the first numerator
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      sel_second_reg <= 1'b0;
      active_num_reg <= `RST_GEAR;
    end else begin
      sel_second_reg <= sel_assigned & NUM_SEL_IN;
      active_num_reg <= (sel_assigned && NUM_SEL_IN) ? num2_reg : num1_reg;
    end
  end

  gear_scaler u_gear (
    .clk(CLK),
    .rst_n(rst_n),
    .cmd_in(cmd_s),
    .num(active_num_reg),
    .den(den_reg),
    .step_out(gear_out),
    .busy(gear_busy)
  );
  assign MOTOR_STEP = gear_out.step;
  assign MOTOR_DIR = gear_out.dir;

  // ==========================================================
  // Position counters and loop tick
  pos_loop_pkg::pos_t cmd_pos_reg, fb_pos_reg;
  logic [16:0] tick_cnt_reg;
  logic tick_reg;

  // Scaled command and feedback positions
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      cmd_pos_reg <= '0;
      fb_pos_reg <= '0;
    end else begin
      if (gear_out.step) begin
        cmd_pos_reg <= gear_out.dir ? cmd_pos_reg - 32'sd1 : cmd_pos_reg + 32'sd1;
      end
      if (FB_STEP) begin
        fb_pos_reg <= FB_DIR ? fb_pos_reg - 32'sd1 : fb_pos_reg + 32'sd1;
      end
    end
  end

  // Loop sample enable, one pulse per millisecond
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= tick_cnt_reg == 17'(TICK_CYCLES - 1);
      tick_cnt_reg <= (tick_cnt_reg == 17'(TICK_CYCLES - 1)) ? '0 : tick_cnt_reg + 17'd1;
    end
  end

  // ==========================================================
  // Command filter, feed-forward and loop
  pos_loop_pkg::fix_t filt_reg, ffs_reg, ff_raw, cmd_fix;
  pos_loop_pkg::pos_t filt_int, prev_reg, vel_reg, err;
  logic [15:0] kp_eff_reg, kp_sw;
  logic signed [63:0] ff_prod;
  assign filt_int = filt_reg[39:`FRAC_BITS];
  assign err = filt_int - fb_pos_reg;
  assign kp_sw = 16'((32'(pgain_reg) * 32'(rate_reg)) / 32'(`PCT_FULL));
  assign ff_prod = (64'(vel_reg) * $signed({48'h0, ffg_reg})) / $signed(64'(`PCT_FULL));
  // Kept signed so a falling command is shifted arithmetically
  assign cmd_fix = 40'(cmd_pos_reg) <<< `FRAC_BITS;
  assign ff_raw = 40'(ff_prod <<< `FRAC_BITS);

  // First order low-pass; the shift approximates the time constant
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      filt_reg <= '0;
    end else if (tick_reg) begin
      if (lpf_reg == `LPF_MIN) begin
        filt_reg <= cmd_fix;
      end else begin
        filt_reg <= filt_reg + ((cmd_fix - filt_reg)
          >>> log2fl(16'(lpf_reg * `LPF_UNIT_MS)));
      end
    end
  end

  // Command velocity per tick feeds the feed-forward path
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      prev_reg <= '0;
      vel_reg <= '0;
    end else if (tick_reg) begin
      prev_reg <= filt_int;
      vel_reg <= filt_int - prev_reg;
    end
  end

  // Feed-forward smoothing
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      ffs_reg <= '0;
    end else if (tick_reg) begin
      ffs_reg <= ffs_reg + ((ff_raw - ffs_reg) >>> log2fl(ffsm_reg));
    end
  end

  // Effective gain, rescaled only while the switch condition holds
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      kp_eff_reg <= `RST_PGAIN;
    end else if (tick_reg) begin
      kp_eff_reg <= GAIN_SW_COND ? kp_sw : pgain_reg;
    end
  end

  // Speed command, product wraps to 32 bits
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      SPEED_CMD <= '0;
    end else if (tick_reg) begin
      SPEED_CMD <= 32'($signed({16'h0, kp_eff_reg}) * err) + ffs_reg[39:`FRAC_BITS];
    end
  end

  // ==========================================================
  // Read data
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    if (aligned) begin
      unique case (idx)
        `IDX_NUM1: rd_mux = {16'h0, num1_reg};
        `IDX_NUM2: rd_mux = {16'h0, num2_reg};
        `IDX_DEN: rd_mux = {16'h0, den_reg};
        `IDX_PGAIN: rd_mux = {16'h0, pgain_reg};
        `IDX_RATE: rd_mux = {16'h0, rate_reg};
        `IDX_FFG: rd_mux = {16'h0, ffg_reg};
        `IDX_FFSM: rd_mux = {16'h0, ffsm_reg};
        `IDX_CTRL: rd_mux = {16'h0, ctrl_reg};
        `IDX_LPF: rd_mux = {16'h0, lpf_reg};
        `IDX_STAT: rd_mux = {29'h0, auto_mode, gear_busy, sel_second_reg};
        `IDX_CPOS: rd_mux = cmd_pos_reg;
        `IDX_PERR: rd_mux = err;
        default: rd_mux = '0;
      endcase
    end
  end

  // Data stands while waitrequest is low
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      AVS_READDATA <= '0;
    end else if (AVS_READ && AVS_WAITREQUEST) begin
      AVS_READDATA <= rd_mux;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!rst_n);

  property p_num1_rng;
    num1_reg >= `GEAR_MIN && num1_reg <= `GEAR_MAX;
  endproperty
  a_num1_rng: assert property (p_num1_rng) else $error("first numerator out of range");

  property p_num2_rng;
    num2_reg >= `GEAR_MIN && num2_reg <= `GEAR_MAX;
  endproperty
  a_num2_rng: assert property (p_num2_rng) else $error("second numerator out of range");

  property p_den_rng;
    den_reg != 16'h0000 && den_reg <= `GEAR_MAX;
  endproperty
  a_den_rng: assert property (p_den_rng) else $error("denominator out of range");

  property p_sel_on;
    sel_assigned && NUM_SEL_IN |=> active_num_reg == $past(num2_reg) && sel_second_reg;
  endproperty
  a_sel_on: assert property (p_sel_on) else $error("second numerator not chosen");

  property p_sel_off;
    !(sel_assigned && NUM_SEL_IN) |=> active_num_reg == $past(num1_reg) && !sel_second_reg;
  endproperty
  a_sel_off: assert property (p_sel_off) else $error("first numerator not chosen");

  property p_lpf_bypass;
    tick_reg && lpf_reg == `LPF_MIN && !gear_out.step |=> filt_int == cmd_pos_reg;
  endproperty
  a_lpf_bypass: assert property (p_lpf_bypass) else $error("zero time constant filtered");

  property p_pgain_rng;
    pgain_reg <= `PGAIN_MAX || auto_mode;
  endproperty
  a_pgain_rng: assert property (p_pgain_rng) else $error("position gain out of range");

  property p_auto;
    auto_mode |=> pgain_reg == 16'(`AUTO_PGAIN_BASE + $past(level) * `AUTO_PGAIN_STEP)
      && ffg_reg == 16'(`AUTO_FFG_BASE + $past(level) * `AUTO_FFG_STEP);
  endproperty
  a_auto: assert property (p_auto) else $error("tuning table not applied");

  property p_switch_on;
    tick_reg && GAIN_SW_COND |=> kp_eff_reg
      == 16'((32'($past(pgain_reg)) * 32'($past(rate_reg))) / 32'(`PCT_FULL));
  endproperty
  a_switch_on: assert property (p_switch_on) else $error("switch rate not applied");

  property p_switch_off;
    tick_reg && !GAIN_SW_COND |=> kp_eff_reg == $past(pgain_reg);
  endproperty
  a_switch_off: assert property (p_switch_off) else $error("gain scaled without condition");

  property p_ffg_rng;
    ffg_reg <= `FFG_MAX && ffsm_reg >= `FFSM_MIN && ffsm_reg <= `FFSM_MAX;
  endproperty
  a_ffg_rng: assert property (p_ffg_rng) else $error("feed-forward setting out of range");

  sequence s_bus_req;
    bus_req && AVS_WAITREQUEST;
  endsequence
  property p_bus_ans;
    s_bus_req |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
  endproperty
  a_bus_ans: assert property (p_bus_ans) else $error("bus answer not one cycle late");
endmodule
`default_nettype wire

/* src/pos_loop_consts.svh */
// Named constants for the position command gear and loop block
`ifndef POS_LOOP_CONSTS_SVH
`define POS_LOOP_CONSTS_SVH
// ==========================================================
// Timing
`define CLK_PERIOD_NS 10
`define TICK_NS 1000000
// ==========================================================
// Register indices, byte address is four times the index
`define IDX_NUM2 10'h10f
`define IDX_NUM1 10'h12c
`define IDX_DEN 10'h12d
`define IDX_PGAIN 10'h200
`define IDX_RATE 10'h201
`define IDX_FFG 10'h202
`define IDX_FFSM 10'h203
`define IDX_CTRL 10'h300
`define IDX_LPF 10'h301
`define IDX_STAT 10'h302
`define IDX_CPOS 10'h303
`define IDX_PERR 10'h304
// ==========================================================
// Reset values
`define RST_GEAR 16'h0001
`define RST_PGAIN 16'h0032
`define RST_RATE 16'h0064
`define RST_FFG 16'h0000
`define RST_FFSM 16'h0005
`define RST_CTRL 16'h0000
`define RST_LPF 16'h0000
// ==========================================================
// Accepted ranges and scale figures
`define GEAR_MIN 16'h0001
`define GEAR_MAX 16'h7fff
`define PGAIN_MIN 16'h0000
`define PGAIN_MAX 16'h03ff
`define RATE_MIN 16'h000a
`define RATE_MAX 16'h01f4
`define FFG_MIN 16'h0000
`define FFG_MAX 16'h0064
`define FFSM_MIN 16'h0002
`define FFSM_MAX 16'h0064
`define LPF_MIN 16'h0000
`define LPF_MAX 16'h03e8
`define LPF_UNIT_MS 16'h000a
`define PCT_FULL 16'h0064
`define FRAC_BITS 8
// ==========================================================
// Control and status fields
`define CTRL_FUNC_MSB 7
`define CTRL_FUNC_LSB 0
`define CTRL_LVL_MSB 11
`define CTRL_LVL_LSB 8
`define CTRL_AUTO_BIT 12
`define FUNC_NUMSEL 8'h0b
`define STAT_SEL_BIT 0
`define STAT_BUSY_BIT 1
`define STAT_AUTO_BIT 2
// ==========================================================
// Automatic tuning table
`define AUTO_PGAIN_BASE 16'h0014
`define AUTO_PGAIN_STEP 16'h000f
`define AUTO_FFG_BASE 16'h0014
`define AUTO_FFG_STEP 16'h0005
`endif

/* src/pos_loop_pkg.sv */
// Types shared by the position command gear and loop block
`default_nettype none
package pos_loop_pkg;
  // ==========================================================
  // Carriers
  typedef logic [15:0] word_t;
  typedef logic signed [31:0] pos_t;
  typedef logic signed [39:0] fix_t;
  typedef struct packed {
    logic step;
    logic dir;
  } step_s;
endpackage
`default_nettype wire

/* src/gear_scaler.sv */
// Electronic gear: scales command pulses by numerator over denominator
`default_nettype none
module gear_scaler (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Incoming command pulse, dir high is reverse
  input wire pos_loop_pkg::step_s cmd_in,
  // Active ratio
  input wire pos_loop_pkg::word_t num,
  input wire pos_loop_pkg::word_t den,
  // Scaled motor pulse
  output pos_loop_pkg::step_s step_out,
  output logic busy
);
  // ==========================================================
  // Remainder accumulator
  logic signed [31:0] acc_reg;
  logic signed [31:0] acc_next;
  logic signed [31:0] add;
  logic signed [31:0] sub;
  logic signed [31:0] dens;
  logic fwd;
  logic rev;

  // One output pulse per cycle at most, so the remainder drains in steps
  always_comb begin
    dens = $signed({16'h0000, den});
    add = '0;
    if (cmd_in.step) begin
      add = cmd_in.dir ? -$signed({16'h0000, num}) : $signed({16'h0000, num});
    end
    fwd = acc_reg >= dens;
    rev = acc_reg <= -dens;
    sub = fwd ? dens : (rev ? -dens : '0);
    acc_next = acc_reg + add - sub;
  end

  // Remainder state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_reg <= '0;
    end else begin
      acc_reg <= acc_next;
    end
  end

  // Output pulse flop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      step_out <= '0;
    end else begin
      step_out <= '{step: fwd | rev, dir: rev};
    end
  end

  assign busy = fwd | rev;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_gear_fwd;
    step_out.step && !step_out.dir |-> $past(acc_reg) >= $past(dens);
  endproperty
  a_gear_fwd: assert property (p_gear_fwd) else $error("forward pulse without remainder");

  sequence s_unit_in;
    cmd_in.step && !cmd_in.dir && num == den && acc_reg == '0;
  endsequence
  property p_gear_unit;
    s_unit_in |=> ##1 (step_out.step && !step_out.dir) ##1
      (step_out.step -> $past(cmd_in.step, 2));
  endproperty
  a_gear_unit: assert property (p_gear_unit) else $error("unit ratio not one to one");
endmodule
`default_nettype wire

/* verification/cmd_pulse_src.sv */
// Motion controller model issuing command pulses with direction
`default_nettype none
module cmd_pulse_src (
  // Clock
  input wire logic clk,
  // Command pulse and direction, dir high is reverse
  output logic step,
  output logic dir
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    step = 1'b0;
    dir = 1'b0;
  end
  // ==========================================================
  // Pulse train, gap 1 keeps step high on consecutive cycles
  task automatic send(input int n, input int gap, input logic d);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      step <= 1'b1;
      dir <= d;
      if (gap > 1) begin
        @(posedge clk);
        step <= 1'b0;
        repeat (gap - 2) @(posedge clk);
      end
    end
    @(posedge clk);
    step <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* verification/position_command_gear_and_loop_tb_top.sv */
// Self-checking bench for the gear, filter and position loop block
`default_nettype none
module position_command_gear_and_loop_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK = 1'b0, ARST_N = 1'b0, AVS_READ = 1'b0, AVS_WRITE = 1'b0;
  logic [11:0] AVS_ADDRESS = 12'h000;
  logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA, SPEED_CMD, r, ecpos = 32'h0;
  logic [3:0] AVS_BYTEENABLE = 4'h3;
  logic AVS_WAITREQUEST, CMD_STEP, CMD_DIR, MOTOR_STEP, MOTOR_DIR;
  logic NUM_SEL_IN = 1'b0, GAIN_SW_COND = 1'b0, FB_STEP = 1'b0, FB_DIR = 1'b0;
  logic signed [31:0] mcnt = 32'sh0;
  int err_total = 0, comparisons = 0, cyc = 0;
  // Register table: address, reset, lowest and highest accepted value
  logic [11:0] ra [8] = '{12'h43c, 12'h4b0, 12'h4b4, 12'h800, 12'h804, 12'h808, 12'h80c, 12'hc04};
  logic [15:0] rs [8] = '{16'h1, 16'h1, 16'h1, 16'h32, 16'h64, 16'h0, 16'h5, 16'h0};
  logic [15:0] mn [8] = '{16'h1, 16'h1, 16'h1, 16'h0, 16'ha, 16'h0, 16'h2, 16'h0};
  logic [15:0] mx [8] = '{16'h7fff, 16'h7fff, 16'h7fff, 16'h3ff, 16'h1f4, 16'h64, 16'h64, 16'h3e8};
  pos_loop_top #(.TICK_CYCLES(20)) uut (.CLK(CLK), .ARST_N(ARST_N),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .CMD_STEP(CMD_STEP), .CMD_DIR(CMD_DIR), .NUM_SEL_IN(NUM_SEL_IN),
    .GAIN_SW_COND(GAIN_SW_COND), .FB_STEP(FB_STEP), .FB_DIR(FB_DIR),
    .MOTOR_STEP(MOTOR_STEP), .MOTOR_DIR(MOTOR_DIR), .SPEED_CMD(SPEED_CMD));
  cmd_pulse_src src (.clk(CLK), .step(CMD_STEP), .dir(CMD_DIR));
  always #5 CLK = ~CLK;
  // Signed count of motor pulses, expected totals are kept apart
  always @(posedge CLK) begin
    if (MOTOR_STEP === 1'b1) mcnt <= MOTOR_DIR ? mcnt - 1 : mcnt + 1;
  end
  // Hang guard, the whole run needs far fewer cycles
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      end_of_test();
    end
  end
  // ==========================================================
  // Helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Request held until the edge that samples waitrequest low
  task automatic bus_wr(input logic [11:0] a, input logic [15:0] d, input logic [3:0] be);
    @(posedge CLK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= {16'h0, d};
    AVS_BYTEENABLE <= be;
    AVS_WRITE <= 1'b1;
    do @(posedge CLK); while (AVS_WAITREQUEST !== 1'b0);
    AVS_WRITE <= 1'b0;
  endtask
  task automatic bus_rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge CLK);
    AVS_ADDRESS <= a;
    AVS_READ <= 1'b1;
    do @(posedge CLK); while (AVS_WAITREQUEST !== 1'b0);
    d = AVS_READDATA;
    AVS_READ <= 1'b0;
  endtask
  // Ratio set up with no motion in flight, then a pulse train
  task automatic gear(input logic [15:0] n1, n2, d, input logic [7:0] fc, input logic si,
      input int np, input int g, input logic dr, input int ex);
    logic [31:0] base;
    bus_wr(12'h4b0, n1, 4'h3);
    bus_wr(12'h43c, n2, 4'h3);
    bus_wr(12'h4b4, d, 4'h3);
    bus_wr(12'hc00, {8'h0, fc}, 4'h3);
    NUM_SEL_IN <= si;
    base = mcnt;
    src.send(np, g, dr);
    repeat (40) @(posedge CLK);
    chk(mcnt - base, ex);
    ecpos = ecpos + ex;
    bus_rd(12'hc0c, r);
    chk(r, ecpos);
    bus_rd(12'hc08, r);
    chk({31'h0, r[0]}, {31'h0, fc == 8'h0b && si});
  endtask
  task automatic end_of_test();
    $display("errors=%0d comparisons=%0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (8) @(posedge CLK);
    ARST_N <= 1'b1;
    repeat (3) @(posedge CLK);
    // Reset values, top of range kept, just outside it dropped
    for (int i = 0; i < 8; i++) begin
      bus_rd(ra[i], r);
      chk(r, {16'h0, rs[i]});
      bus_wr(ra[i], mx[i], 4'h3);
      bus_rd(ra[i], r);
      chk(r, {16'h0, mx[i]});
      bus_wr(ra[i], mx[i] + 16'h1, 4'h3);
      bus_rd(ra[i], r);
      chk(r, {16'h0, mx[i]});
      if (mn[i] != 16'h0) begin
        bus_wr(ra[i], mn[i] - 16'h1, 4'h3);
        bus_rd(ra[i], r);
        chk(r, {16'h0, mx[i]});
      end
      bus_wr(ra[i], rs[i], 4'h3);
    end
    // Low lane only, then unmapped and misaligned places
    bus_wr(12'h4b0, 16'h0a0a, 4'h1);
    bus_rd(12'h4b0, r);
    chk(r, 32'h0000000a);
    bus_rd(12'h004, r);
    chk(r, 32'h0);
    bus_rd(12'h4b1, r);
    chk(r, 32'h0);
    // Half ratio back to back, select unassigned, assigned on and off, reverse
    gear(16'h1, 16'h1, 16'h2, 8'h00, 1'b0, 10, 1, 1'b0, 5);
    gear(16'h1, 16'h3, 16'h1, 8'h00, 1'b1, 4, 3, 1'b0, 4);
    gear(16'h1, 16'h3, 16'h1, 8'h0b, 1'b1, 4, 3, 1'b0, 12);
    gear(16'h1, 16'h3, 16'h1, 8'h0b, 1'b0, 4, 3, 1'b0, 4);
    gear(16'h2, 16'h3, 16'h1, 8'h00, 1'b0, 2, 3, 1'b1, -4);
    // Loop: error with bypassed filter, then switched gain doubles the command
    bus_wr(12'h800, 16'h0100, 4'h3);
    bus_wr(12'h804, 16'h00c8, 4'h3);
    gear(16'h1, 16'h1, 16'h1, 8'h00, 1'b0, 8, 2, 1'b0, 8);
    FB_DIR <= 1'b1;
    repeat (3) begin
      @(posedge CLK);
      FB_STEP <= 1'b1;
      @(posedge CLK);
      FB_STEP <= 1'b0;
    end
    repeat (300) @(posedge CLK);
    bus_rd(12'hc10, r);
    chk(r, ecpos + 32'h3);
    chk(SPEED_CMD, (ecpos + 32'h3) * 32'h100);
    GAIN_SW_COND <= 1'b1;
    repeat (300) @(posedge CLK);
    chk(SPEED_CMD, (ecpos + 32'h3) * 32'h200);
    // Filter on: a falling command must settle exactly on the new position
    bus_wr(12'hc04, 16'h0001, 4'h3);
    gear(16'h1, 16'h1, 16'h1, 8'h00, 1'b0, 4, 2, 1'b1, -4);
    repeat (2000) @(posedge CLK);
    bus_rd(12'hc10, r);
    chk(r, ecpos + 32'h3);
    // Automatic tuning at level 3 overrides both gains
    bus_wr(12'hc00, 16'h1300, 4'h3);
    repeat (4) @(posedge CLK);
    bus_wr(12'h800, 16'h0010, 4'h3);
    bus_rd(12'h800, r);
    chk(r, 32'h00000041);
    bus_rd(12'h808, r);
    chk(r, 32'h00000023);
    bus_rd(12'hc08, r);
    chk({31'h0, r[2]}, 32'h1);
    end_of_test();
  end
endmodule
`default_nettype wire
